//--- ubrb_pkg.sv
package ubrb_pkg;
   localparam int CA_ID_W = 16;
   localparam int QDEPTH_W = 8;
   localparam logic [7:0] QDEPTH_SAT = 8'hFF;
   localparam int QUERY_MAX = 6;
   localparam int NUM_CA = 8;
   localparam int CA_IDX_W = 3;
   localparam int EXP_W = 4;
   localparam int RETRY_W = 5;
   localparam int WIN_W = 16;
   localparam logic [15:0] LFSR_SEED = 16'hACE1;
   localparam int RESP_TIME_NS = 2000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int RESP_CYCLES = RESP_TIME_NS / CLK_PERIOD_NS;
   localparam int REQ_ITEMS = 3;
   typedef enum logic [1:0] {SIG_NONE, SIG_REQUEST, SIG_QUERY_REPLY, SIG_DUMMY} ubrb_sig_t;
endpackage : ubrb_pkg

//--- ubrb_depth_table.sv
`timescale 1ns/100ps
module ubrb_depth_table #(
   parameter int DEPTH = 8,
   parameter int AW = 3,
   parameter int DW = 8
) (
   input wire logic mclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [DEPTH];
   if (DEPTH > (1 << AW)) begin : gBadDepth
      $error("depth exceeds address range");
   end
   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end
   always_ff @(posedge mclk) begin
      rdata <= mem[raddr];
   end
endmodule : ubrb_depth_table

//--- ubrb_lfsr.sv
`timescale 1ns/100ps
module ubrb_lfsr (
   input wire logic mclk,
   input wire logic rst,
   output logic [15:0] value
);
   import ubrb_pkg::*;
   always_ff @(posedge mclk) begin
      if (rst) begin
         value <= LFSR_SEED;
      end else begin
         value <= {value[14:0], value[15] ^ value[13] ^ value[12] ^ value[10]};
      end
   end
endmodule : ubrb_lfsr

//--- ubrb_uplink_request.sv
`timescale 1ns/100ps
// Behaviour
// - aggregate id 16 bits, depth 8 bits
// - request message only in short signalling
// - reported aggregates chosen freely by terminal
// - query of one to six, reply in order
// - reply in next granted short slot
// - fixed-rate aggregates need no requests
// - polled with no traffic sends empty request
// - data header carries own aggregate depth
// - depth saturates at all ones
// - poll bit excludes own aggregate
// - poll bit enable per aggregate configured
// - contention window carries only short signalling
// - window exponent n gives 0..2^n-1
// - entry loads initial window
// - random deferral over contention opportunities
// - no response means lost, redraw
// - double window, capped at maximum
// - stop after maximum retries, await grant
// - grant while deferring abandons contention
// - contention support is optional
// - poll bit one means poll me
// - empty grant filled with dummy units
module ubrb_uplink_request #(
   parameter int NCA = ubrb_pkg::NUM_CA,
   parameter bit CONTENTION_EN = 1'b1
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic depthWe,
   input wire logic [ubrb_pkg::CA_IDX_W-1:0] depthIdx,
   input wire logic [15:0] depthCount,
   input wire logic [NCA-1:0] pollEnable,
   input wire logic [NCA-1:0] fixedRate,
   input wire logic [NCA-1:0] trafficPending,
   input wire logic [ubrb_pkg::CA_IDX_W-1:0] hdrIdx,
   input wire logic hdrStrobe,
   input wire logic queryValid,
   input wire logic [2:0] queryCount,
   input wire logic [3*ubrb_pkg::QUERY_MAX-1:0] queryIdx,
   input wire logic [3*ubrb_pkg::CA_IDX_W-1:0] reqIdx,
   input wire logic [ubrb_pkg::CA_ID_W*3-1:0] reqCaId,
   input wire logic wantRequest,
   input wire logic shortGrant,
   input wire logic polled,
   input wire logic dataGrant,
   input wire logic haveData,
   input wire logic contentionOpp,
   input wire logic requestAck,
   input wire logic [ubrb_pkg::EXP_W-1:0] initExp,
   input wire logic [ubrb_pkg::EXP_W-1:0] maxExp,
   input wire logic [ubrb_pkg::RETRY_W-1:0] maxRetries,
   output logic [7:0] hdrDepth,
   output logic hdrPoll,
   output logic sigValid,
   output ubrb_pkg::ubrb_sig_t sigKind,
   output logic sigInContention,
   output logic [2:0] sigCount,
   output logic [ubrb_pkg::CA_ID_W*3-1:0] sigCaId,
   output logic [ubrb_pkg::QDEPTH_W*ubrb_pkg::QUERY_MAX-1:0] sigDepth,
   output logic dummyFill,
   output logic contending,
   output logic contentionGaveUp
);
   import ubrb_pkg::*;

   typedef enum {ST_IDLE, ST_DEFER, ST_WAIT, ST_GAVEUP} ubrb_state_t;

   // saturating depth code
   function automatic logic [7:0] satDepth(input logic [15:0] cnt);
      satDepth = (cnt > 16'd254) ? QDEPTH_SAT : cnt[7:0];
   endfunction : satDepth

   function automatic logic [15:0] expMask(input logic [EXP_W-1:0] n);
      expMask = 16'((32'd1 << n) - 32'd1);
   endfunction : expMask

   if (NCA > (1 << CA_IDX_W)) begin : gBadNca
      $error("too many aggregates for index width");
   end

   logic [7:0] depthShadow [NCA];
   logic [15:0] rnd;
   logic [7:0] tblData;
   ubrb_state_t state_reg;
   logic [EXP_W-1:0] winExp_reg;
   logic [15:0] deferCnt_reg;
   logic [RETRY_W-1:0] retries_reg;
   logic [15:0] respCnt_reg;
   logic queryPend_reg;
   logic [2:0] queryCnt_reg;
   logic [3*QUERY_MAX-1:0] queryIdx_reg;
   logic [NCA-1:0] otherPend;
   logic [47:0] qdAll;
   logic grantNow;
   logic hdrStrobeDly_reg;
   logic pollBit_reg;

   ubrb_depth_table #(.DEPTH(NCA), .AW(CA_IDX_W), .DW(QDEPTH_W)) depthTable (
      .mclk(mclk),
      .we(depthWe),
      .waddr(depthIdx),
      .wdata(satDepth(depthCount)),
      .raddr(hdrIdx),
      .rdata(tblData)
   );

   ubrb_lfsr rng (
      .mclk(mclk),
      .rst(rst),
      .value(rnd)
   );

   always_ff @(posedge mclk) begin
      if (rst) begin
         for (int i = 0; i < NCA; i++) depthShadow[i] <= 8'h00;
      end else if (depthWe) begin
         depthShadow[depthIdx] <= satDepth(depthCount);
      end
   end

   // strobe delayed one cycle to meet the registered table read
   always_ff @(posedge mclk) begin
      if (rst) begin
         hdrStrobeDly_reg <= 1'b0;
         pollBit_reg <= 1'b0;
      end else begin
         hdrStrobeDly_reg <= hdrStrobe;
         if (hdrStrobe) begin
            pollBit_reg <= |otherPend;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         hdrDepth <= 8'h00;
      end else if (hdrStrobeDly_reg) begin
         hdrDepth <= tblData;
      end
   end

   always_comb begin
      otherPend = trafficPending & pollEnable & ~fixedRate;
      otherPend[hdrIdx] = 1'b0;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         hdrPoll <= 1'b0;
      end else if (hdrStrobeDly_reg) begin
         hdrPoll <= pollBit_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         queryPend_reg <= 1'b0;
         queryCnt_reg <= 3'd0;
         queryIdx_reg <= '0;
      end else if (queryValid && queryCount != 3'd0 && queryCount <= 3'(QUERY_MAX)) begin
         queryPend_reg <= 1'b1;
         queryCnt_reg <= queryCount;
         queryIdx_reg <= queryIdx;
      end else if (shortGrant && queryPend_reg) begin
         queryPend_reg <= 1'b0;
      end
   end

   always_comb begin
      qdAll = '0;
      for (int k = 0; k < QUERY_MAX; k++) begin
         if (k < int'(queryCnt_reg)) begin
            qdAll[k*8 +: 8] = depthShadow[queryIdx_reg[k*3 +: 3]];
         end
      end
   end

   assign grantNow = shortGrant || polled;

   // short signalling output
   always_ff @(posedge mclk) begin
      if (rst) begin
         sigValid <= 1'b0;
         sigKind <= SIG_NONE;
         sigInContention <= 1'b0;
         sigCount <= 3'd0;
         sigCaId <= '0;
         sigDepth <= '0;
         dummyFill <= 1'b0;
      end else begin
         sigValid <= 1'b0;
         sigKind <= SIG_NONE;
         sigInContention <= 1'b0;
         dummyFill <= 1'b0;
         if (shortGrant && queryPend_reg) begin
            sigValid <= 1'b1;
            sigKind <= SIG_QUERY_REPLY;
            sigCount <= queryCnt_reg;
            sigDepth <= qdAll;
         end else if (grantNow || (state_reg == ST_DEFER && contentionOpp
                                   && deferCnt_reg == 16'd0)) begin
            sigValid <= 1'b1;
            sigKind <= SIG_REQUEST;
            sigInContention <= !grantNow;
            sigCaId <= reqCaId;
            sigDepth <= '0;
            sigCount <= wantRequest ? 3'(REQ_ITEMS) : 3'd0;
            for (int j = 0; j < REQ_ITEMS; j++) begin
               if (wantRequest) sigDepth[j*8 +: 8] <= depthShadow[reqIdx[j*3 +: 3]];
            end
         end else if (dataGrant && !haveData) begin
            sigValid <= 1'b1;
            sigKind <= SIG_DUMMY;
            dummyFill <= 1'b1;
         end
      end
   end

   // back-off machine
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         winExp_reg <= '0;
         deferCnt_reg <= 16'd0;
         retries_reg <= '0;
         respCnt_reg <= 16'd0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (CONTENTION_EN && wantRequest && !grantNow && !dataGrant) begin
                  winExp_reg <= initExp;
                  deferCnt_reg <= rnd & expMask(initExp);
                  retries_reg <= '0;
                  state_reg <= ST_DEFER;
               end
            end
            ST_DEFER: begin
               if (grantNow || dataGrant) begin
                  state_reg <= ST_IDLE;
                  retries_reg <= '0;
               end else if (contentionOpp) begin
                  if (deferCnt_reg == 16'd0) begin
                     respCnt_reg <= 16'(RESP_CYCLES);
                     state_reg <= ST_WAIT;
                  end else begin
                     deferCnt_reg <= deferCnt_reg - 16'd1;
                  end
               end
            end
            ST_WAIT: begin
               if (requestAck || grantNow || dataGrant) begin
                  state_reg <= ST_IDLE;
                  retries_reg <= '0;
               end else if (respCnt_reg == 16'd0) begin
                  if (retries_reg + 1'b1 >= maxRetries) begin
                     state_reg <= ST_GAVEUP;
                  end else begin
                     retries_reg <= retries_reg + 1'b1;
                     if (winExp_reg < maxExp) begin
                        winExp_reg <= winExp_reg + 1'b1;
                        deferCnt_reg <= rnd & expMask(winExp_reg + 1'b1);
                     end else begin
                        winExp_reg <= maxExp;
                        deferCnt_reg <= rnd & expMask(maxExp);
                     end
                     state_reg <= ST_DEFER;
                  end
               end else begin
                  respCnt_reg <= respCnt_reg - 16'd1;
               end
            end
            ST_GAVEUP: begin
               if (grantNow || dataGrant) begin
                  state_reg <= ST_IDLE;
                  retries_reg <= '0;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         contending <= 1'b0;
         contentionGaveUp <= 1'b0;
      end else begin
         contending <= (state_reg == ST_DEFER) || (state_reg == ST_WAIT);
         contentionGaveUp <= state_reg == ST_GAVEUP;
      end
   end
endmodule : ubrb_uplink_request

//--- ubrb_uplink_request_assertions.sv
`timescale 1ns/100ps
module ubrb_uplink_request_chk #(
   parameter int NCA = 8
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [NCA-1:0] pollEnable,
   input wire logic [NCA-1:0] fixedRate,
   input wire logic [NCA-1:0] trafficPending,
   input wire logic [2:0] hdrIdx,
   input wire logic hdrStrobe,
   input wire logic shortGrant,
   input wire logic polled,
   input wire logic dataGrant,
   input wire logic contentionOpp,
   input wire logic hdrPoll,
   input wire logic sigValid,
   input wire ubrb_pkg::ubrb_sig_t sigKind,
   input wire logic sigInContention,
   input wire logic [2:0] sigCount,
   input wire logic dummyFill,
   input wire logic contending,
   input wire logic contentionGaveUp
);
   import ubrb_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_reply_after_grant: assert property (sigValid && sigKind == SIG_QUERY_REPLY |->
      $past(shortGrant)) else $error("reply without grant");
   a_reply_count_range: assert property (sigValid && sigKind == SIG_QUERY_REPLY |->
      sigCount inside {[1:6]}) else $error("reply count out of range");
   a_contention_in_opp: assert property (sigValid && sigInContention |->
      $past(contentionOpp) && sigKind == SIG_REQUEST) else $error("contention send misplaced");
   a_poll_answered: assert property (polled |=>
      sigValid && sigKind != SIG_DUMMY) else $error("poll not answered");
   a_poll_bit_value: assert property ($past(hdrStrobe, 2) |->
      hdrPoll == |($past(trafficPending, 2) & $past(pollEnable, 2) & ~$past(fixedRate, 2)
      & ~(NCA'(1) << $past(hdrIdx, 2)))) else $error("poll bit wrong");
   a_gaveup_quiet: assert property (contentionGaveUp |->
      !contending && !(sigValid && sigInContention)) else $error("contending after give up");
   a_grant_abandons: assert property (contending && (dataGrant || shortGrant || polled) |->
      ##2 !contending) else $error("grant did not end contention");
   a_dummy_on_grant: assert property (dummyFill |->
      $past(dataGrant)) else $error("dummy without grant");
endmodule : ubrb_uplink_request_chk

//--- ubrb_ap_model.sv
`timescale 1ns/100ps
module ubrb_ap_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ackOn,
   input wire logic ackSlow,
   input wire logic sigValid,
   input wire logic sigInContention,
   output logic contentionOpp,
   output logic requestAck,
   output logic [3:0] initExp,
   output logic [3:0] maxExp,
   output logic [4:0] maxRetries
);
   logic [1:0] oppCnt;
   logic [7:0] ackCnt;
   assign initExp = 4'h1;
   assign maxExp = 4'h3;
   assign maxRetries = 5'h04;
   always_ff @(posedge mclk) begin
      oppCnt <= rst ? 2'h0 : oppCnt + 2'h1;
      contentionOpp <= !rst && oppCnt == 2'h3;
   end
   always_ff @(posedge mclk) begin
      requestAck <= !rst && ackCnt == 8'h01;
      if (rst) ackCnt <= 8'h00;
      else if (sigValid && sigInContention && ackOn) ackCnt <= ackSlow ? 8'hB4 : 8'h03;
      else if (ackCnt != 8'h00) ackCnt <= ackCnt - 8'h01;
   end
endmodule : ubrb_ap_model

//--- ubrb_uplink_request_tb_top.sv
`timescale 1ns/100ps
module ubrb_uplink_request_tb_top;
   import ubrb_pkg::*;
   typedef struct {ubrb_sig_t k; logic [2:0] c; logic [47:0] d; logic [47:0] m;} ubrb_exp_t;
   logic mclk, rst, depthWe, hdrStrobe, queryValid, wantRequest, shortGrant, polled, dataGrant;
   logic haveData, requestAck, contentionOpp, ackOn, ackSlow, hdrPoll, sigValid, sigInContention;
   logic dummyFill, contending, contentionGaveUp;
   logic [2:0] depthIdx, hdrIdx, queryCount, sigCount;
   logic [15:0] depthCount;
   logic [7:0] pollEnable, fixedRate, trafficPending, hdrDepth, depth[8];
   logic [17:0] queryIdx;
   logic [8:0] reqIdx;
   logic [47:0] reqCaId, sigCaId, sigDepth;
   logic [3:0] initExp, maxExp;
   logic [4:0] maxRetries;
   ubrb_sig_t sigKind;
   ubrb_exp_t expq[$];
   ubrb_exp_t got;
   int nErrors, numChecks, nCont;
   ubrb_uplink_request #(.NCA(8)) DUT (.mclk, .rst, .depthWe, .depthIdx, .depthCount,
      .pollEnable, .fixedRate, .trafficPending, .hdrIdx, .hdrStrobe, .queryValid, .queryCount,
      .queryIdx, .reqIdx, .reqCaId, .wantRequest, .shortGrant, .polled, .dataGrant, .haveData,
      .contentionOpp, .requestAck, .initExp, .maxExp, .maxRetries, .hdrDepth, .hdrPoll,
      .sigValid, .sigKind, .sigInContention, .sigCount, .sigCaId, .sigDepth, .dummyFill,
      .contending, .contentionGaveUp);
   ubrb_ap_model uAp (.mclk, .rst, .ackOn, .ackSlow, .sigValid, .sigInContention,
      .contentionOpp, .requestAck, .initExp, .maxExp, .maxRetries);
   task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk
   task automatic close_out();
      if (nErrors == 0 && numChecks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   task automatic contend(input logic ack, input logic slow);
      nCont = 0;
      {ackOn, ackSlow, wantRequest} <= {ack, slow, 1'b1};
      tick(1);
      wantRequest <= 1'b0;
      tick(2);
      for (int w = 0; w < 3000 && (ack ? contending !== 1'b0 : contentionGaveUp !== 1'b1); w++)
         tick(1);
   endtask : contend
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      if (!rst && sigValid === 1'b1 && sigKind !== SIG_DUMMY) begin
         if (sigInContention === 1'b1) begin
            nCont++;
            chk("contCaId", sigCaId, reqCaId);
         end else if (expq.size() == 0) begin
            chk("spurious", 48'(sigKind), 48'h0);
         end else begin
            got = expq.pop_front();
            chk("sigKind", 48'(sigKind), 48'(got.k));
            chk("sigCount", 48'(sigCount), 48'(got.c));
            chk("sigDepth", sigDepth & got.m, got.d);
            if (got.c == 3'h3) chk("sigCaId", sigCaId, reqCaId);
         end
      end
   end
   initial begin
      logic [15:0] cnt;
      logic [17:0] qi;
      ubrb_exp_t e;
      {depthWe, hdrStrobe, queryValid, wantRequest, shortGrant, polled, dataGrant} = '0;
      {haveData, ackOn, ackSlow, depthIdx, depthCount, hdrIdx, queryCount, queryIdx} = '0;
      {pollEnable, fixedRate, trafficPending, reqIdx, reqCaId} = '0;
      rst = 1'b1;
      void'($urandom(80));
      tick(4);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         cnt = i == 0 ? 16'h00FE : i == 1 ? 16'h00FF : 16'($urandom_range(0, 600));
         depth[i] = cnt > 16'h00FE ? 8'hFF : cnt[7:0];
         {depthWe, depthIdx, depthCount} <= {1'b1, 3'(i), cnt};
         tick(1);
      end
      depthWe <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         {pollEnable, fixedRate, trafficPending} <= 24'($urandom);
         {hdrStrobe, hdrIdx} <= {1'b1, 3'(i)};
         tick(1);
         hdrStrobe <= 1'b0;
         tick(3);
         chk("hdrDepth", 48'(hdrDepth), 48'(depth[i]));
         chk("hdrPoll", 48'(hdrPoll),
            48'(|(trafficPending & pollEnable & ~fixedRate & ~(8'h01 << i))));
      end
      for (int k = 1; k <= 6; k++) begin
         qi = 18'($urandom);
         e = '{SIG_QUERY_REPLY, 3'(k), 48'h0, (48'h1 << (8 * k)) - 48'h1};
         for (int j = 0; j < k; j++) e.d[8*j+:8] = depth[qi[3*j+:3]];
         expq.push_back(e);
         {queryValid, queryCount, queryIdx} <= {1'b1, 3'(k), qi};
         tick(1);
         {queryValid, shortGrant} <= 2'b01;
         tick(1);
         shortGrant <= 1'b0;
         tick(3);
      end
      qi = 18'($urandom);
      e = '{SIG_REQUEST, 3'h3, 48'h0, 48'hFFFFFF};
      for (int j = 0; j < 3; j++) e.d[8*j+:8] = depth[qi[3*j+:3]];
      {queryValid, wantRequest, reqIdx, reqCaId} <= {2'b01, qi[8:0], 48'({$urandom, $urandom})};
      tick(1);
      queryValid <= 1'b0;
      tick(3);
      expq.push_back(e);
      shortGrant <= 1'b1;
      tick(1);
      {shortGrant, wantRequest, trafficPending} <= '0;
      tick(3);
      expq.push_back('{SIG_REQUEST, 3'h0, 48'h0, 48'h0});
      polled <= 1'b1;
      tick(1);
      polled <= 1'b0;
      tick(3);
      contend(1'b1, 1'b0);
      chk("nCont", 48'(nCont), 48'h1);
      chk("contending", 48'(contending), 48'h0);
      contend(1'b1, 1'b1);
      chk("nCont", 48'(nCont), 48'h1);
      contend(1'b0, 1'b0);
      chk("retries", 48'(nCont), 48'(maxRetries));
      chk("gaveUp", 48'(contentionGaveUp), 48'h1);
      dataGrant <= 1'b1;
      tick(1);
      dataGrant <= 1'b0;
      tick(1);
      chk("dummyFill", 48'(dummyFill), 48'h1);
      tick(1);
      chk("gaveUp", 48'(contentionGaveUp), 48'h0);
      chk("pending", 48'(expq.size()), 48'h0);
      close_out();
   end
   initial begin
      tick(20000);
      nErrors++;
      close_out();
   end
endmodule : ubrb_uplink_request_tb_top
bind ubrb_uplink_request ubrb_uplink_request_chk #(.NCA(NCA)) uChk (.mclk, .rst, .pollEnable,
   .fixedRate, .trafficPending, .hdrIdx, .hdrStrobe, .shortGrant, .polled, .dataGrant,
   .contentionOpp, .hdrPoll, .sigValid, .sigKind, .sigInContention, .sigCount, .dummyFill,
   .contending, .contentionGaveUp);
